// >>> src/ssc_pkg.sv
`default_nettype none
package ssc_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int BURST_W     = 2;
    localparam int HALVES      = 2;
    localparam int PIN_W       = 18;
    localparam int SYNC_STAGES = 3;
    localparam int BUF_DEPTH   = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 16'h0000;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [PIN_W-1:0]   PIN_RST   = 18'h00000;
    localparam logic [HALVES-1:0]  HALF_RST  = 2'h0;
    localparam logic               OE_N_RST  = 1'b1;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic              par;
        logic [BYTE_W-1:0] data;
    } ssc_half_t;

    typedef struct packed {
        ssc_half_t hi;
        ssc_half_t lo;
    } ssc_word_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        ssc_word_t         data;
        logic [HALVES-1:0] be;
    } ssc_wreq_t;

    localparam int WREQ_W = $bits(ssc_wreq_t);

    typedef enum logic [2:0] {
        SSC_DESEL = 3'b001,
        SSC_READ  = 3'b010,
        SSC_WRITE = 3'b100
    } ssc_op_t;

endpackage
`default_nettype wire

// >>> src/ssc_pair_buf.sv
`timescale 1ns/1ns
`default_nettype none
module ssc_pair_buf #(
    parameter int WIDTH = ssc_pkg::WREQ_W,
    parameter int DEPTH = ssc_pkg::BUF_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             push;
    logic             pop;

    // ****************************************
    // Handshake
    // ****************************************
    // Ready and valid are registered so the ports come straight from flops
    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + CNT_W'(1);
        end else if (pop && !push) begin
            count_d = count_q - CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count_q   <= count_d;
            in_ready  <= count_d != CNT_W'(DEPTH);
            out_valid <= count_d != '0;
        end
    end

    // ****************************************
    // Storage
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    assign out_data = mem_q[rd_ptr_q];

endmodule
`default_nettype wire

// >>> src/ssc_sram_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Burst step sampled low advances the two-bit wraparound burst counter.
// - Parameter picks linear or interleaved burst order.
// - Burst step ignored when any strobe is taken with chip select low.
// - Chip select high with controller strobe low deselects the device.
// - Taken strobe loads full address, keeps low two bits as start, clears counter.
// - Processor strobe ignored entirely while chip select is high.
// - Output enable low drives read data if device was selected.
// - Each half floats when its write enable is sampled low.
// - Pin data captured at the clock edge feeds the array write.
// - Parity bits travel with their byte half and its write enable.
// - Processor strobe with chip select low starts a burst read.
// - Controller strobe alone starts a burst, write if any enable low.
// - No strobe: stepped or same address, write if selected and any enable low.
// - Interleaved order XORs start value with the burst count.
// - Linear order adds the burst count to the start value.
// - Processor-started write ignores enables first cycle, writes the next.
// - Both strobes together count as a processor-started access.
module ssc_sram_ctrl #(
    parameter bit INTERLEAVED = 1'b1
) (
    input  wire logic                          ref_clk,
    input  wire logic                          reset_n,
    input  wire logic [ssc_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic                          chip_select_n,
    input  wire logic                          processor_address_strobe_n,
    input  wire logic                          controller_address_strobe_n,
    input  wire logic                          burst_step_n,
    input  wire logic                          upper_byte_write_n,
    input  wire logic                          lower_byte_write_n,
    input  wire logic                          output_enable_n,
    input  wire logic [15:0]                   dq_i,
    output var  logic [15:0]                   dq_o,
    output var  logic [15:0]                   dq_oe,
    input  wire logic [1:0]                    parity_lines_i,
    output var  logic [1:0]                    parity_lines_o,
    output var  logic [1:0]                    parity_lines_oe,
    output var  logic                          write_ready,
    output var  logic [ssc_pkg::ADDR_W-1:0]    core_rd_addr,
    input  wire ssc_pkg::ssc_word_t            core_rd_data,
    output var  logic                          core_wr_valid,
    input  wire logic                          core_wr_ready,
    output var  ssc_pkg::ssc_wreq_t            core_wr_req
);

    // ****************************************
    // Strobe decode
    // ****************************************
    logic                          proc_take;
    logic                          ctrl_take;
    logic                          load;
    logic                          deselect;
    logic                          step;
    logic [ssc_pkg::HALVES-1:0]    we_raw;
    logic [ssc_pkg::HALVES-1:0]    we_eff;
    logic                          wr_now;

    // Processor strobe only counts with chip select low, and wins a tie
    assign proc_take = !chip_select_n && !processor_address_strobe_n;
    assign ctrl_take = !chip_select_n && processor_address_strobe_n
                       && !controller_address_strobe_n;
    assign load      = proc_take || ctrl_take;
    assign deselect  = chip_select_n && !controller_address_strobe_n;
    assign step      = !burst_step_n && !load && !deselect;

    assign we_raw = {!upper_byte_write_n, !lower_byte_write_n};
    // Enables in a processor strobe cycle belong to a tag check, not a write
    assign we_eff = proc_take ? ssc_pkg::HALF_RST : we_raw;

    // ****************************************
    // Access state
    // ****************************************
    ssc_pkg::ssc_op_t op_q;
    ssc_pkg::ssc_op_t op_d;
    logic             selected_d;

    always_comb begin
        op_d = op_q;
        case (op_q)
            ssc_pkg::SSC_DESEL: begin
                if (load) begin
                    op_d = (we_eff != ssc_pkg::HALF_RST) ? ssc_pkg::SSC_WRITE
                                                         : ssc_pkg::SSC_READ;
                end
            end
            ssc_pkg::SSC_READ, ssc_pkg::SSC_WRITE: begin
                if (deselect) begin
                    op_d = ssc_pkg::SSC_DESEL;
                end else if (we_eff != ssc_pkg::HALF_RST) begin
                    op_d = ssc_pkg::SSC_WRITE;
                end else begin
                    op_d = ssc_pkg::SSC_READ;
                end
            end
            default: begin
                op_d = ssc_pkg::SSC_DESEL;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_q <= ssc_pkg::SSC_DESEL;
        end else begin
            op_q <= op_d;
        end
    end

    assign selected_d = op_d != ssc_pkg::SSC_DESEL;
    // A deselected part never writes, even on a no-strobe cycle
    assign wr_now     = (op_d == ssc_pkg::SSC_WRITE);

    // ****************************************
    // Address register and burst counter
    // ****************************************
    logic [ssc_pkg::ADDR_W-1:0]  addr_q;
    logic [ssc_pkg::BURST_W-1:0] start_q;
    logic [ssc_pkg::BURST_W-1:0] count_q;
    logic [ssc_pkg::ADDR_W-1:0]  addr_d;
    logic [ssc_pkg::BURST_W-1:0] start_d;
    logic [ssc_pkg::BURST_W-1:0] count_d;
    logic [ssc_pkg::BURST_W-1:0] low_d;

    always_comb begin
        addr_d  = addr_q;
        start_d = start_q;
        count_d = count_q;
        if (load) begin
            addr_d  = addr_i;
            start_d = addr_i[ssc_pkg::BURST_W-1:0];
            count_d = ssc_pkg::BURST_RST;
        end else if (step) begin
            count_d = count_q + ssc_pkg::BURST_ONE;
        end
    end

    // Counting from the start value keeps both orders a single adder or xor
    assign low_d = INTERLEAVED ? (start_d ^ count_d)
                               : (start_d + count_d);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_q  <= ssc_pkg::ADDR_RST;
            start_q <= ssc_pkg::BURST_RST;
            count_q <= ssc_pkg::BURST_RST;
        end else begin
            addr_q  <= addr_d;
            start_q <= start_d;
            count_q <= count_d;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_rd_addr <= ssc_pkg::ADDR_RST;
        end else begin
            core_rd_addr <= {addr_d[ssc_pkg::ADDR_W-1:ssc_pkg::BURST_W], low_d};
        end
    end

    // ****************************************
    // Write path
    // ****************************************
    ssc_pkg::ssc_word_t pin_word;
    ssc_pkg::ssc_wreq_t wreq;

    // Parity bit rides with its byte half
    assign pin_word.hi.par  = parity_lines_i[1];
    assign pin_word.hi.data = dq_i[15:8];
    assign pin_word.lo.par  = parity_lines_i[0];
    assign pin_word.lo.data = dq_i[7:0];

    // Pin data taken at this edge is what the array later receives
    assign wreq.addr = {addr_d[ssc_pkg::ADDR_W-1:ssc_pkg::BURST_W], low_d};
    assign wreq.data = pin_word;
    assign wreq.be   = we_eff;

    // Writes offered while write_ready is low are lost; the far side must wait
    ssc_pair_buf #(
        .WIDTH (ssc_pkg::WREQ_W),
        .DEPTH (ssc_pkg::BUF_DEPTH)
    ) u_wbuf (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (wr_now),
        .in_ready  (write_ready),
        .in_data   (wreq),
        .out_valid (core_wr_valid),
        .out_ready (core_wr_ready),
        .out_data  (core_wr_req)
    );

    // ****************************************
    // Output enable synchroniser
    // ****************************************
    logic [ssc_pkg::SYNC_STAGES-1:0] oe_sync_q;
    logic                            oe_n_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_sync_q <= {ssc_pkg::SYNC_STAGES{ssc_pkg::OE_N_RST}};
        end else begin
            oe_sync_q <= {oe_sync_q[ssc_pkg::SYNC_STAGES-2:0], output_enable_n};
        end
    end

    // Accept a change only once the last two stages agree
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_n_q <= ssc_pkg::OE_N_RST;
        end else if (oe_sync_q[1] == oe_sync_q[2]) begin
            oe_n_q <= oe_sync_q[2];
        end
    end

    // ****************************************
    // Data pins
    // ****************************************
    logic [ssc_pkg::HALVES-1:0] drive;

    // Taken from this edge's inputs, so the enables land at this edge, a cycle ahead of the read data
    // Sampled write enables float their half whatever output enable says
    assign drive = {ssc_pkg::HALVES{!oe_n_q && selected_d}} & ~we_raw;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_o            <= ssc_pkg::PIN_RST[15:0];
            parity_lines_o  <= ssc_pkg::HALF_RST;
            dq_oe           <= ssc_pkg::PIN_RST[15:0];
            parity_lines_oe <= ssc_pkg::HALF_RST;
        end else begin
            dq_o            <= {core_rd_data.hi.data, core_rd_data.lo.data};
            parity_lines_o  <= {core_rd_data.hi.par, core_rd_data.lo.par};
            dq_oe           <= {{ssc_pkg::BYTE_W{drive[1]}}, {ssc_pkg::BYTE_W{drive[0]}}};
            parity_lines_oe <= drive;
        end
    end

endmodule
`default_nettype wire

// >>> sim/ssc_sram_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ssc_sram_ctrl_checker #(
    parameter bit INTERLEAVED = 1'b1
) (
    input wire logic               ref_clk,
    input wire logic               reset_n,
    input wire logic [15:0]        addr_i,
    input wire logic               chip_select_n,
    input wire logic               processor_address_strobe_n,
    input wire logic               controller_address_strobe_n,
    input wire logic               burst_step_n,
    input wire logic               upper_byte_write_n,
    input wire logic               lower_byte_write_n,
    input wire logic               output_enable_n,
    input wire logic [15:0]        dq_oe,
    input wire logic [1:0]         parity_lines_oe,
    input wire logic               write_ready,
    input wire logic [15:0]        core_rd_addr,
    input wire logic               core_wr_valid,
    input wire logic               core_wr_ready,
    input wire ssc_pkg::ssc_wreq_t core_wr_req
);
    logic        take_p;
    logic        take_c;
    logic        desel;
    logic        sel_q;
    logic [15:0] base_q;
    logic [1:0]  cnt_q;
    logic [1:0]  low;
    assign take_p = !chip_select_n && !processor_address_strobe_n;
    assign take_c = !chip_select_n && processor_address_strobe_n && !controller_address_strobe_n;
    assign desel  = chip_select_n && !controller_address_strobe_n;
    assign low    = INTERLEAVED ? base_q[1:0] ^ cnt_q : base_q[1:0] + cnt_q;

    // ****************************************
    // Reference burst address
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_q  <= 1'b0;
            base_q <= 16'h0000;
            cnt_q  <= 2'h0;
        end else if (take_p || take_c) begin
            sel_q  <= 1'b1;
            base_q <= addr_i;
            cnt_q  <= 2'h0;
        end else if (desel) begin
            sel_q <= 1'b0;
        end else if (sel_q && !burst_step_n) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_oe_high;
        output_enable_n [*5];
    endsequence

    a_addr_follow: assert property (sel_q |-> core_rd_addr == {base_q[15:2], low})
        else $error("burst address off the reference");
    a_proc_load: assert property (take_p |=> core_rd_addr == $past(addr_i))
        else $error("processor strobe did not load address");
    a_desel_float: assert property (desel |=> dq_oe == 16'h0000 && parity_lines_oe == 2'h0)
        else $error("pins driven after deselect");
    a_upper_float: assert property (!upper_byte_write_n |=> dq_oe[15:8] == 8'h00 && !parity_lines_oe[1])
        else $error("upper half driven during write");
    a_lower_float: assert property (!lower_byte_write_n |=> dq_oe[7:0] == 8'h00 && !parity_lines_oe[0])
        else $error("lower half driven during write");
    a_oe_float: assert property (s_oe_high |=> dq_oe == 16'h0000 && parity_lines_oe == 2'h0)
        else $error("pins driven with output enable high");
    a_proc_wr_skip: assert property (take_p && !core_wr_valid |=> !core_wr_valid)
        else $error("write taken in processor strobe cycle");
    a_ctrl_wr_push: assert property (take_c && write_ready && !(upper_byte_write_n && lower_byte_write_n) |=> core_wr_valid)
        else $error("controller write not queued");
    a_wreq_hold: assert property (core_wr_valid && !core_wr_ready |=> core_wr_valid && $stable(core_wr_req))
        else $error("write request changed while stalled");
endmodule
bind ssc_sram_ctrl ssc_sram_ctrl_checker #(.INTERLEAVED(INTERLEAVED)) i_chk (.ref_clk, .reset_n,
    .addr_i, .chip_select_n, .processor_address_strobe_n, .controller_address_strobe_n,
    .burst_step_n, .upper_byte_write_n, .lower_byte_write_n, .output_enable_n, .dq_oe,
    .parity_lines_oe, .write_ready, .core_rd_addr, .core_wr_valid, .core_wr_ready, .core_wr_req);
`default_nettype wire

// >>> sim/ssc_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module ssc_array_model (
    input  wire logic               ref_clk,
    input  wire logic               stall,
    input  wire logic [15:0]        core_rd_addr,
    output var  ssc_pkg::ssc_word_t core_rd_data,
    input  wire logic               core_wr_valid,
    output var  logic               core_wr_ready,
    input  wire ssc_pkg::ssc_wreq_t core_wr_req
);
    logic [17:0] mem [0:65535];
    // Known pattern so reads need no prior writes
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = {i[15:0], 2'h1};
    end
    always_comb core_rd_data = mem[core_rd_addr];
    always_comb core_wr_ready = !stall;
    always_ff @(posedge ref_clk) begin
        if (core_wr_valid && core_wr_ready && core_wr_req.be[1]) mem[core_wr_req.addr][17:9] <= core_wr_req.data.hi;
        if (core_wr_valid && core_wr_ready && core_wr_req.be[0]) mem[core_wr_req.addr][8:0] <= core_wr_req.data.lo;
    end
endmodule
`default_nettype wire

// >>> sim/ssc_sram_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ssc_sram_ctrl_bench;
    localparam logic [5:0] IDL = 6'h1f;
    logic               ref_clk = 1'b0;
    logic               reset_n = 1'b0;
    logic [15:0]        addr_i = 16'h0000;
    logic               chip_select_n = 1'b1;
    logic               processor_address_strobe_n = 1'b1;
    logic               controller_address_strobe_n = 1'b1;
    logic               burst_step_n = 1'b1;
    logic               upper_byte_write_n = 1'b1;
    logic               lower_byte_write_n = 1'b1;
    logic               output_enable_n = 1'b0;
    logic [17:0]        pin_d = 18'h00000;
    logic               drv_en = 1'b0;
    logic               stall = 1'b0;
    int                 err_total = 0;
    int                 cmp_count = 0;
    logic [15:0]        dq_i, dq_o, dq_oe, core_rd_addr;
    logic [1:0]         parity_lines_i, parity_lines_o, parity_lines_oe;
    logic               write_ready, core_wr_valid, core_wr_ready;
    ssc_pkg::ssc_word_t core_rd_data;
    ssc_pkg::ssc_wreq_t core_wr_req;
    logic [17:0]        out18, oe18, pins;
    assign out18 = {parity_lines_o[1], dq_o[15:8], parity_lines_o[0], dq_o[7:0]};
    assign oe18  = {parity_lines_oe[1], dq_oe[15:8], parity_lines_oe[0], dq_oe[7:0]};
    // Undriven pins show the inverse, never a stale value
    assign pins  = drv_en ? pin_d : (out18 & oe18) | (~pin_d & ~oe18);
    assign dq_i  = {pins[16:9], pins[7:0]};
    assign parity_lines_i = {pins[17], pins[8]};

    ssc_sram_ctrl #(.INTERLEAVED(1'b1)) i_ssc_sram_ctrl (.ref_clk, .reset_n, .addr_i,
        .chip_select_n, .processor_address_strobe_n, .controller_address_strobe_n, .burst_step_n,
        .upper_byte_write_n, .lower_byte_write_n, .output_enable_n, .dq_i, .dq_o, .dq_oe,
        .parity_lines_i, .parity_lines_o, .parity_lines_oe, .write_ready, .core_rd_addr,
        .core_rd_data, .core_wr_valid, .core_wr_ready, .core_wr_req);
    ssc_array_model i_ssc_array_model (.ref_clk, .stall, .core_rd_addr, .core_rd_data,
        .core_wr_valid, .core_wr_ready, .core_wr_req);

    always #5 ref_clk = ~ref_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    // Control order: chip select, proc strobe, ctrl strobe, step, upper write, lower write
    task automatic cyc(input logic [5:0] ctl, input logic [15:0] a, input logic [17:0] d, input logic de);
        @(posedge ref_clk);
        {chip_select_n, processor_address_strobe_n, controller_address_strobe_n, burst_step_n,
            upper_byte_write_n, lower_byte_write_n} <= ctl;
        addr_i <= a;
        pin_d  <= d;
        drv_en <= de;
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(IDL, 16'h0000, 18'h00000, 1'b0);
        #1;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatched %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_burst(input logic [1:0] s);
        logic [15:0] a;
        a = {14'h0123, s};
        cyc(6'h0b, a, 18'h00000, 1'b0);
        for (int n = 0; n < 4; n++) begin
            cyc(n < 3 ? 6'h1b : IDL, 16'hffff, 18'h00000, 1'b0);
            #1;
            chk(core_rd_addr, {a[15:2], s ^ 2'(n)});
            if (n > 0) chk(out18, {a[15:2], s ^ 2'(n - 1), 2'h1});
        end
        $display("burst from %0d done", s);
    endtask
    task automatic t_oe;
        @(posedge ref_clk) output_enable_n <= 1'b1;
        idle(6);
        chk(oe18, 18'h00000);
        @(posedge ref_clk) output_enable_n <= 1'b0;
        idle(6);
        chk(oe18, 18'h3ffff);
        cyc(6'h1d, 16'h0000, 18'h00000, 1'b0);
        idle(1);
        chk(oe18, 18'h001ff);
        $display("output enable test done");
    endtask
    task automatic t_desel;
        cyc(6'h37, 16'h0000, 18'h00000, 1'b0);
        cyc(6'h28, 16'h0200, 18'h00000, 1'b0);
        #1;
        chk(oe18, 18'h00000);
        cyc(6'h3f, 16'h0000, 18'h00000, 1'b0);
        #1;
        chk(core_wr_valid, 1'b0);
        chk(core_rd_addr, 16'h048f);
        $display("deselect test done");
    endtask
    task automatic t_writes;
        @(posedge ref_clk) output_enable_n <= 1'b1;
        idle(5);
        cyc(6'h16, 16'h0040, 18'h2d5a5, 1'b1);
        idle(4);
        chk(i_ssc_array_model.mem[16'h0040], 18'h001a5);
        cyc(6'h04, 16'h0080, 18'h15555, 1'b1);
        cyc(6'h1c, 16'h0000, 18'h2aaaa, 1'b1);
        #1;
        chk(core_wr_valid, 1'b0);
        idle(4);
        chk(i_ssc_array_model.mem[16'h0080], 18'h2aaaa);
        $display("write test done");
    endtask
    task automatic t_stall;
        @(posedge ref_clk) stall <= 1'b1;
        cyc(6'h14, 16'h0100, 18'h11111, 1'b1);
        cyc(6'h14, 16'h0101, 18'h12222, 1'b1);
        cyc(6'h14, 16'h0102, 18'h13333, 1'b1);
        #1;
        chk(write_ready, 1'b0);
        idle(3);
        chk(core_wr_valid, 1'b1);
        @(posedge ref_clk) stall <= 1'b0;
        idle(4);
        chk(i_ssc_array_model.mem[16'h0100], 18'h11111);
        chk(i_ssc_array_model.mem[16'h0101], 18'h12222);
        chk(i_ssc_array_model.mem[16'h0102], 18'h00409);
        $display("stall test done");
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int s = 0; s < 4; s++) t_burst(2'(s));
        t_oe();
        t_desel();
        t_writes();
        t_stall();
        close_out();
    end
    initial begin
        #20000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
